// >>> rtl/pism_pkg.sv
// package for the peripheral input source mux: offsets, fields, codes, carriers
package pism_pkg;
   // register offsets (byte addresses = 4 * index)
   localparam logic [7:0] PWM_SRC_IDX = 8'h18;
   localparam logic [7:0] DAC_SRC_IDX = 8'h19;
   localparam logic [7:0] PORTB_FN0_IDX = 8'h15;
   localparam logic [7:0] PORTB_FN1_IDX = 8'h16;
   localparam logic [7:0] PROT_IDX = 8'h12;
   localparam logic [9:0] PWM_SRC_ADDR = {PWM_SRC_IDX, 2'b00};
   localparam logic [9:0] DAC_SRC_ADDR = {DAC_SRC_IDX, 2'b00};
   localparam logic [9:0] PORTB_FN0_ADDR = {PORTB_FN0_IDX, 2'b00};
   localparam logic [9:0] PORTB_FN1_ADDR = {PORTB_FN1_IDX, 2'b00};
   localparam logic [9:0] PROT_ADDR = {PROT_IDX, 2'b00};
   localparam logic [9:0] PEREN_ADDR = 10'h0a0;
   // field positions
   localparam int FAULT2_BIT = 13;
   localparam int FAULT1_BIT = 11;
   localparam int PAIR3_LSB = 6;
   localparam int PAIR2_LSB = 3;
   localparam int PAIR1_LSB = 0;
   localparam int DAC1_LSB = 4;
   localparam int DAC0_LSB = 0;
   localparam int PB0_BIT = 0;
   localparam int PB7_BIT = 0;
   // writable masks; reserved bits are held at zero
   localparam logic [15:0] PWM_SRC_MASK = 16'h29ff;
   localparam logic [15:0] DAC_SRC_MASK = 16'h0077;
   localparam logic [15:0] PORTB_FN0_MASK = 16'h0001;
   localparam logic [15:0] PORTB_FN1_MASK = 16'h0001;
   localparam logic [15:0] PEREN_MASK = 16'h0081;
   localparam logic [15:0] RESET_VALUE = 16'h0000;
   localparam logic [1:0] PROT_RESET = 2'b00;
   // pair source codes
   localparam logic [2:0] PAIR_PIN = 3'h0;
   localparam logic [2:0] PAIR_TIMER = 3'h1;
   localparam logic [2:0] PAIR_ADC = 3'h2;
   localparam logic [2:0] PAIR_CMPA = 3'h3;
   localparam logic [2:0] PAIR_CMPB = 3'h4;
   // dac sync codes
   localparam logic [2:0] SYNC_PIT = 3'h0;
   localparam logic [2:0] SYNC_PWM = 3'h3;
   localparam logic [2:0] SYNC_TIMER_CH0 = 3'h4;
   localparam logic [2:0] SYNC_TIMER_CH1 = 3'h5;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [9:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pism_wb_req_t;

   typedef struct packed {
      logic [3:0] timerA;      // timer_a_chan3..0 outputs
      logic comparatorAOut;
      logic comparatorBOut;
      logic intervalTimerZero;
      logic pwmReloadSync;
      logic [2:0] adcAboveHigh;  // per sample 2..0
      logic [2:0] adcBelowLow;
      logic fault1Pin;
      logic fault2Pin;
      logic [2:0] pairPin;       // pin sources, index 0 for pair one
   } pism_sources_t;

   typedef struct packed {
      logic fault1;
      logic fault2;
      logic [2:0] pairEven;
      logic [2:0] pairOdd;
      logic dacZeroSync;
      logic dacOneSync;
   } pism_selected_t;

   typedef struct packed {
      logic pin0PerEn;
      logic pin0UsesI2c;     // 0 queued spi clock, 1 i2c scl
      logic pin7PerEn;
      logic pin7UsesI2c;     // 0 serial tx, 1 i2c scl
   } pism_pin_ctl_t;
endpackage

// >>> rtl/pism_mux.sv
// register file and source multiplexers for peripheral inputs and port b pins
`timescale 1ns/1ps
// How it works
// - port b pin 0 function bit: 0 queued spi clock, 1 i2c clock
// - port b pin 7 function bit: 0 serial transmit, 1 i2c clock
// - one source-select register per peripheral type, field per multi-source input
// - bit 13 feeds fault two from pin or comparator b
// - bit 11 feeds fault one from pin or comparator a
// - bits 8-6 pick third pair source; 000 reserved
// - bits 5-3 pick second pair source, pin default
// - bits 2-0 pick first pair source, pin default
// - adc above high drives even 0 odd 1; below low the reverse
// - bits 6-4 pick dac one sync source
// - bits 2-0 pick dac zero sync source, same codes
// - peripheral-enable 0 gives pin to gpio, 1 to function fields
// - two-bit protection with lock; the lock is cleared only by reset
module pism_mux (
   input wire logic clk,
   input wire logic reset,
   input wire pism_pkg::pism_wb_req_t wbReq,
   output logic wbAck,
   output logic [31:0] wbDatOut,
   output logic wbErr,
   input wire pism_pkg::pism_sources_t sources,
   output pism_pkg::pism_selected_t selected,
   output pism_pkg::pism_pin_ctl_t pinCtl
);
   import pism_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // pair source: returns {even, odd}
   function automatic logic [1:0] pairPick(input logic [2:0] code, input logic pinSrc,
         input logic timerSrc, input logic above, input logic below,
         input logic cmpA, input logic cmpB, input logic pinAllowed);
      logic [1:0] r;
      r = 2'b00;
      case (code)
         PAIR_PIN: r = pinAllowed ? {pinSrc, ~pinSrc} : 2'b00;
         PAIR_TIMER: r = {timerSrc, ~timerSrc};
         PAIR_ADC: begin
            if (above) r = 2'b01;
            else if (below) r = 2'b10;
            else r = 2'b00;
         end
         PAIR_CMPA: r = {cmpA, ~cmpA};
         PAIR_CMPB: r = {cmpB, ~cmpB};
         default: r = 2'b00;
      endcase
      return r;
   endfunction

   function automatic logic syncPick(input logic [2:0] code, input pism_sources_t s);
      logic r;
      r = 1'b0;
      case (code)
         SYNC_PIT: r = s.intervalTimerZero;
         SYNC_PWM: r = s.pwmReloadSync;
         SYNC_TIMER_CH0: r = s.timerA[0];
         SYNC_TIMER_CH1: r = s.timerA[1];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [15:0] pwmSrc_reg, pwmSrc_next;
   logic [15:0] dacSrc_reg, dacSrc_next;
   logic [15:0] portbFn0_reg, portbFn0_next;
   logic [15:0] portbFn1_reg, portbFn1_next;
   logic [15:0] perEn_reg, perEn_next;
   logic [1:0] prot_reg, prot_next;
   logic ack_reg, ack_next;
   logic err_reg, err_next;
   logic [31:0] rdat_reg, rdat_next;

   logic req;
   logic writeNow;
   logic protOn;
   logic protLocked;
   logic mapped;
   logic [15:0] wdat;
   logic [15:0] rd;

   assign req = wbReq.cyc && wbReq.stb && !ack_reg && !err_reg;
   assign writeNow = req && wbReq.we && mapped;
   assign protOn = prot_reg[0];
   assign protLocked = prot_reg[1];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
         input logic [3:0] sel, input logic [15:0] mask);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
      return (old & ~m) | (d & m);
   endfunction

   // decode kept apart so the write strobe never feeds back into it
   always_comb begin
      mapped = 1'b1;
      rd = 16'h0000;
      case (wbReq.adr)
         PWM_SRC_ADDR: rd = pwmSrc_reg;
         DAC_SRC_ADDR: rd = dacSrc_reg;
         PORTB_FN0_ADDR: rd = portbFn0_reg;
         PORTB_FN1_ADDR: rd = portbFn1_reg;
         PEREN_ADDR: rd = perEn_reg;
         PROT_ADDR: rd = {14'h0000, prot_reg};
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      pwmSrc_next = pwmSrc_reg;
      dacSrc_next = dacSrc_reg;
      portbFn0_next = portbFn0_reg;
      portbFn1_next = portbFn1_reg;
      perEn_next = perEn_reg;
      prot_next = prot_reg;
      ack_next = 1'b0;
      err_next = 1'b0;
      rdat_next = rdat_reg;
      wdat = wbReq.dat[15:0];
      if (req) begin
         ack_next = mapped;
         err_next = !mapped;
         rdat_next = {16'h0000, rd};
      end
      if (writeNow) begin
         // protected writes are acknowledged but dropped
         if (!protOn) begin
            case (wbReq.adr)
               PWM_SRC_ADDR: begin
                  pwmSrc_next = merge(pwmSrc_reg, wdat, wbReq.sel, PWM_SRC_MASK);
               end
               DAC_SRC_ADDR: begin
                  dacSrc_next = merge(dacSrc_reg, wdat, wbReq.sel, DAC_SRC_MASK);
               end
               PORTB_FN0_ADDR: begin
                  portbFn0_next = merge(portbFn0_reg, wdat, wbReq.sel, PORTB_FN0_MASK);
               end
               PORTB_FN1_ADDR: begin
                  portbFn1_next = merge(portbFn1_reg, wdat, wbReq.sel, PORTB_FN1_MASK);
               end
               PEREN_ADDR: begin
                  perEn_next = merge(perEn_reg, wdat, wbReq.sel, PEREN_MASK);
               end
               default: ;
            endcase
         end
         if (wbReq.adr == PROT_ADDR && wbReq.sel[0] && !protLocked) begin
            prot_next = wdat[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pwmSrc_reg <= RESET_VALUE;
         dacSrc_reg <= RESET_VALUE;
         portbFn0_reg <= RESET_VALUE;
         portbFn1_reg <= RESET_VALUE;
         perEn_reg <= RESET_VALUE;
         prot_reg <= PROT_RESET;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         pwmSrc_reg <= pwmSrc_next;
         dacSrc_reg <= dacSrc_next;
         portbFn0_reg <= portbFn0_next;
         portbFn1_reg <= portbFn1_next;
         perEn_reg <= perEn_next;
         prot_reg <= prot_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wbAck = ack_reg;
   assign wbErr = err_reg;
   assign wbDatOut = rdat_reg;

   // ----------------------------------------------------------------
   // source multiplexers
   // ----------------------------------------------------------------
   // external pins are synchronised; internal sources share the clock
   logic [4:0] pinMeta_reg, pinSync_reg;
   pism_selected_t sel_next, sel_reg;
   pism_pin_ctl_t pin_next, pin_reg;
   logic [1:0] p1, p2, p3;

   always_comb begin
      p1 = pairPick(pwmSrc_reg[PAIR1_LSB +: 3], pinSync_reg[2], sources.timerA[0],
            sources.adcAboveHigh[0], sources.adcBelowLow[0],
            sources.comparatorAOut, sources.comparatorBOut, 1'b1);
      p2 = pairPick(pwmSrc_reg[PAIR2_LSB +: 3], pinSync_reg[3], sources.timerA[2],
            sources.adcAboveHigh[1], sources.adcBelowLow[1],
            sources.comparatorAOut, sources.comparatorBOut, 1'b1);
      // code 000 is reserved for the third pair, so no pin source
      p3 = pairPick(pwmSrc_reg[PAIR3_LSB +: 3], pinSync_reg[4], sources.timerA[3],
            sources.adcAboveHigh[2], sources.adcBelowLow[2],
            sources.comparatorAOut, sources.comparatorBOut, 1'b0);
      sel_next.fault2 = pwmSrc_reg[FAULT2_BIT] ? sources.comparatorBOut
            : pinSync_reg[1];
      sel_next.fault1 = pwmSrc_reg[FAULT1_BIT] ? sources.comparatorAOut
            : pinSync_reg[0];
      sel_next.pairEven = {p3[1], p2[1], p1[1]};
      sel_next.pairOdd = {p3[0], p2[0], p1[0]};
      sel_next.dacOneSync = syncPick(dacSrc_reg[DAC1_LSB +: 3], sources);
      sel_next.dacZeroSync = syncPick(dacSrc_reg[DAC0_LSB +: 3], sources);
      pin_next.pin0PerEn = perEn_reg[0];
      pin_next.pin0UsesI2c = portbFn0_reg[PB0_BIT];
      pin_next.pin7PerEn = perEn_reg[7];
      pin_next.pin7UsesI2c = portbFn1_reg[PB7_BIT];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pinMeta_reg <= 5'h00;
         pinSync_reg <= 5'h00;
         sel_reg <= '0;
         pin_reg <= '0;
      end else begin
         pinMeta_reg <= {sources.pairPin, sources.fault2Pin, sources.fault1Pin};
         pinSync_reg <= pinMeta_reg;
         sel_reg <= sel_next;
         pin_reg <= pin_next;
      end
   end

   assign selected = sel_reg;
   assign pinCtl = pin_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fault2_source: assert property (
      pwmSrc_reg[FAULT2_BIT] |=> selected.fault2 == $past(sources.comparatorBOut))
      else $error("fault two not from comparator b");
   a_fault1_source: assert property (
      !pwmSrc_reg[FAULT1_BIT] |=> selected.fault1 == $past(pinSync_reg[0]))
      else $error("fault one not from its pin");
   a_pair_adc_high: assert property (
      pwmSrc_reg[PAIR1_LSB +: 3] == PAIR_ADC && sources.adcAboveHigh[0]
      |=> !selected.pairEven[0] && selected.pairOdd[0])
      else $error("adc above high wrong pair levels");
   a_pair3_reserved: assert property (
      pwmSrc_reg[PAIR3_LSB +: 3] == PAIR_PIN |=> selected.pairEven[2] == 1'b0
      && selected.pairOdd[2] == 1'b0)
      else $error("reserved third pair code not idle");
   a_dac_timer_sync: assert property (
      dacSrc_reg[DAC1_LSB +: 3] == SYNC_TIMER_CH1
      |=> selected.dacOneSync == $past(sources.timerA[1]))
      else $error("dac one sync not timer a1");
   a_dac_reserved: assert property (
      dacSrc_reg[DAC0_LSB +: 3] inside {3'h1, 3'h2, 3'h6, 3'h7} |=> !selected.dacZeroSync)
      else $error("reserved dac zero code not idle");
   a_protect_blocks: assert property (
      protOn && writeNow && wbReq.adr == PWM_SRC_ADDR |=> $stable(pwmSrc_reg))
      else $error("protected write changed register");
   a_lock_holds: assert property (
      protLocked |=> $stable(prot_reg))
      else $error("locked protection changed");
   a_reserved_zero: assert property (
      (pwmSrc_reg & ~PWM_SRC_MASK) == 16'h0000 && (dacSrc_reg & ~DAC_SRC_MASK) == 16'h0000)
      else $error("reserved bits not zero");
   a_change_by_write: assert property (
      !writeNow |=> $stable(pwmSrc_reg) && $stable(dacSrc_reg))
      else $error("select changed without write");
   a_pin0_function: assert property (
      ##1 pinCtl.pin0UsesI2c == $past(portbFn0_reg[PB0_BIT]))
      else $error("pin 0 function mismatch");
   a_ack_once: assert property (
      wbAck |=> !wbAck)
      else $error("ack held two cycles");
   a_pin7_function: assert property (
      ##1 pinCtl.pin7UsesI2c == $past(portbFn1_reg[PB7_BIT]))
      else $error("pin 7 function mismatch");
   a_pin_enable: assert property (
      ##1 pinCtl.pin0PerEn == $past(perEn_reg[0])
      && pinCtl.pin7PerEn == $past(perEn_reg[7]))
      else $error("pin peripheral enable mismatch");
   a_pair2_timer: assert property (
      pwmSrc_reg[PAIR2_LSB +: 3] == PAIR_TIMER
      |=> selected.pairEven[1] == $past(sources.timerA[2])
      && selected.pairOdd[1] != $past(sources.timerA[2]))
      else $error("second pair not from timer channel 2");
   a_pair1_cmpb: assert property (
      pwmSrc_reg[PAIR1_LSB +: 3] == PAIR_CMPB
      |=> selected.pairEven[0] == $past(sources.comparatorBOut))
      else $error("first pair not from comparator b");
   a_dac0_pit: assert property (
      dacSrc_reg[DAC0_LSB +: 3] == SYNC_PIT
      |=> selected.dacZeroSync == $past(sources.intervalTimerZero))
      else $error("dac zero sync not interval timer");
   a_portb_reserved: assert property (
      (portbFn0_reg & ~PORTB_FN0_MASK) == 16'h0000
      && (portbFn1_reg & ~PORTB_FN1_MASK) == 16'h0000)
      else $error("port b reserved bits not zero");

   c_pair_adc: cover property (pwmSrc_reg[PAIR2_LSB +: 3] == PAIR_ADC && sources.adcBelowLow[1]);
   c_locked: cover property (prot_reg == 2'b11);
   c_dac_pwm: cover property (dacSrc_reg[DAC0_LSB +: 3] == SYNC_PWM);
   c_err: cover property (wbErr);
   c_pin0_i2c: cover property (pinCtl.pin0PerEn && pinCtl.pin0UsesI2c);
endmodule // pism_mux

// >>> testbench/pism_periph_model.sv
// stand-in for the peripherals that feed the source mux
`timescale 1ns/1ps
module pism_periph_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [18:0] scene,
   output pism_pkg::pism_sources_t sources
);
   import pism_pkg::*;
   // ------------------------------
   // peripheral outputs, one flop each
   // ------------------------------
   pism_sources_t sourcesReg;
   pism_sources_t sourcesNext;
   pism_sources_t raw;
   always_comb begin
      // each pin-fed input has exactly one pin of its own
      raw = pism_sources_t'(scene);
      sourcesNext = raw;
      // one result cannot be above high and below low at once
      sourcesNext.adcBelowLow = raw.adcBelowLow & ~raw.adcAboveHigh;
   end
   always_ff @(posedge clk) begin
      sourcesReg <= reset ? '0 : sourcesNext;
   end
   assign sources = sourcesReg;
endmodule // pism_periph_model

// >>> testbench/tb_peripheral_input_source_mux.sv
// self-checking bench for the peripheral input source mux
`timescale 1ns/1ps
module tb_peripheral_input_source_mux;
   import pism_pkg::*;
   logic clk;
   logic reset;
   pism_wb_req_t req;
   logic wbAck;
   logic wbErr;
   logic [31:0] wbDatOut;
   logic [18:0] scene;
   pism_sources_t src;
   pism_selected_t sel;
   pism_pin_ctl_t pinCtl;
   int failCount;
   int nChecks;
   logic [31:0] rd;
   logic errSeen;
   logic [9:0] addrs [5];
   logic [15:0] masks [5];

   pism_mux dut (.clk(clk), .reset(reset), .wbReq(req), .wbAck(wbAck),
      .wbDatOut(wbDatOut), .wbErr(wbErr), .sources(src), .selected(sel),
      .pinCtl(pinCtl));
   pism_periph_model model (.clk(clk), .reset(reset), .scene(scene),
      .sources(src));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------
   // helpers
   // ------------------------------
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single classic cycle; ack is read with its value at the sampling edge
   task automatic wb(input logic we, input logic [9:0] a, input logic [15:0] d,
      input logic [3:0] sl);
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sl, dat: {16'h0000, d}};
      // no cycle budget here; only the watchdog ends a wait with no answer
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1 && wbErr !== 1'b1);
      rd = wbDatOut;
      errSeen = wbErr;
      req <= '0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      wb(1'b1, a, d, 4'h3);
   endtask

   task automatic rc(input logic [9:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000, 4'h3);
      chk(rd, {16'h0000, e});
   endtask

   task automatic do_reset;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
   endtask

   function automatic logic dsync(input logic [2:0] c, input pism_sources_t s);
      case (c)
         SYNC_PIT: return s.intervalTimerZero;
         SYNC_PWM: return s.pwmReloadSync;
         SYNC_TIMER_CH0: return s.timerA[0];
         SYNC_TIMER_CH1: return s.timerA[1];
         default: return 1'b0;
      endcase
   endfunction

   function automatic pism_selected_t ref_sel(input logic [15:0] pw,
      input logic [15:0] dc, input pism_sources_t s);
      pism_selected_t r;
      logic [2:0] c;
      logic v;
      logic hit;
      r = '0;
      r.fault2 = pw[FAULT2_BIT] ? s.comparatorBOut : s.fault2Pin;
      r.fault1 = pw[FAULT1_BIT] ? s.comparatorAOut : s.fault1Pin;
      for (int p = 0; p < 3; p++) begin
         c = pw[3*p +: 3];
         hit = 1'b1;
         v = 1'b0;
         case (c)
            PAIR_PIN: if (p < 2) v = s.pairPin[p]; else hit = 1'b0;
            PAIR_TIMER: v = s.timerA[(p == 0) ? 0 : p + 1];
            PAIR_CMPA: v = s.comparatorAOut;
            PAIR_CMPB: v = s.comparatorBOut;
            default: hit = 1'b0;
         endcase
         r.pairEven[p] = hit & v;
         r.pairOdd[p] = hit & ~v;
         if (c == PAIR_ADC) begin
            r.pairEven[p] = s.adcBelowLow[p] & ~s.adcAboveHigh[p];
            r.pairOdd[p] = s.adcAboveHigh[p];
         end
      end
      r.dacOneSync = dsync(dc[6:4], s);
      r.dacZeroSync = dsync(dc[2:0], s);
      return r;
   endfunction

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      logic [2:0] cc;
      logic [3:0] k;
      logic [15:0] pw;
      logic [15:0] dc;
      failCount = 0;
      nChecks = 0;
      reset = 1'b1;
      req = '0;
      scene = '0;
      addrs = '{PWM_SRC_ADDR, DAC_SRC_ADDR, PORTB_FN0_ADDR, PORTB_FN1_ADDR, PEREN_ADDR};
      masks = '{PWM_SRC_MASK, DAC_SRC_MASK, PORTB_FN0_MASK, PORTB_FN1_MASK, PEREN_MASK};
      do_reset();
      for (int i = 0; i < 5; i++) begin
         rc(addrs[i], RESET_VALUE);
         wr(addrs[i], 16'hffff);
         rc(addrs[i], masks[i]);
         wr(addrs[i], 16'h0000);
      end
      wb(1'b1, PWM_SRC_ADDR, 16'hffff, 4'h1);
      rc(PWM_SRC_ADDR, 16'h00ff & PWM_SRC_MASK);
      wr(PWM_SRC_ADDR, 16'h0000);
      rc(10'h3fc, 16'h0000);
      chk(errSeen, 1'b1);
      for (int i = 0; i < 16; i++) begin
         k = 4'(i);
         wr(PEREN_ADDR, 16'h0000);
         repeat (2) @(posedge clk);
         wr(PORTB_FN0_ADDR, {15'h0000, k[0]});
         wr(PORTB_FN1_ADDR, {15'h0000, k[1]});
         wr(PEREN_ADDR, {8'h00, k[3], 6'h00, k[2]});
         repeat (2) @(posedge clk);
         chk(pinCtl, {k[2], k[0], k[3], k[1]});
      end
      for (int c = 0; c < 8; c++) begin
         cc = 3'(c);
         pw = {2'b00, cc[0], 1'b0, cc[1], 2'b00, cc, cc, cc};
         dc = {9'h000, cc, 1'b0, ~cc};
         wr(PWM_SRC_ADDR, pw);
         wr(DAC_SRC_ADDR, dc);
         for (int b = 0; b < 38; b++) begin
            scene <= (b < 19) ? 19'h1 << b : ~(19'h1 << (b - 19));
            repeat (6) @(posedge clk);
            chk(sel, ref_sel(pw, dc, src));
         end
      end
      wr(PROT_ADDR, 16'h0001);
      wr(PWM_SRC_ADDR, 16'h0001);
      rc(PWM_SRC_ADDR, pw);
      wr(PROT_ADDR, 16'h0000);
      wr(PWM_SRC_ADDR, 16'h0001);
      rc(PWM_SRC_ADDR, 16'h0001);
      wr(PROT_ADDR, 16'h0003);
      wr(PROT_ADDR, 16'h0000);
      rc(PROT_ADDR, 16'h0003);
      wr(PWM_SRC_ADDR, 16'h0000);
      rc(PWM_SRC_ADDR, 16'h0001);
      do_reset();
      @(posedge clk);
      chk(sel, 32'h0);
      rc(PROT_ADDR, 16'h0000);
      rc(PWM_SRC_ADDR, 16'h0000);
      wr(PROT_ADDR, 16'h0002);
      wr(DAC_SRC_ADDR, 16'h0005);
      wr(PROT_ADDR, 16'h0001);
      rc(PROT_ADDR, 16'h0002);
      rc(DAC_SRC_ADDR, 16'h0005);
      final_report();
   end

   // whole run needs about 2.3k cycles; wide margin for slow answers
   initial begin
      #400000;
      failCount++;
      final_report();
   end
endmodule // tb_peripheral_input_source_mux
